// ===== common/hofl_pkg.sv
package hofl_pkg;
    localparam int OPT_W = 22;
    localparam int OPT_LOCK = 0;
    localparam int OPT_ISP = 1;
    localparam int OPT_PUB = 4;
    localparam int OPT_ARB = 5;
    localparam int OPT_IAP = 6;
    localparam int OPT_BOHI = 9;
    localparam int OPT_BO0RE = 12;
    localparam int OPT_BO1RE = 13;
    localparam int OPT_WDRE = 14;
    localparam int OPT_WDNS = 15;
    localparam int OPT_WDHW = 16;
    localparam int OPT_WDIDLE = 17;
    localparam int OPT_PS = 18;
    localparam int OPT_WP = 21;
    localparam logic [OPT_W-1:0] OPT_ERASED = 22'h000000;
    localparam int ADDR_W = 5;
    localparam logic [4:0] REG_OPT = 5'h00;
    localparam logic [4:0] REG_WDOG = 5'h04;
    localparam logic [4:0] REG_DBG = 5'h08;
    localparam logic [4:0] REG_IAP = 5'h0c;
    localparam logic [4:0] REG_BOOT = 5'h10;
    localparam int WD_PS = 0;
    localparam int WD_IDL = 3;
    localparam int WD_PDRUN = 4;
    localparam int WD_EN = 5;
    localparam int WD_RSTEN = 6;
    localparam int WD_OVF = 7;
    localparam logic [7:0] WD_PROT_MASK = 8'h5f;
    localparam logic [7:0] WD_RST = 8'h00;
    localparam int DBG_EN = 0;
    localparam logic [7:0] DBG_RST = 8'h01;
    localparam logic [12:0] FLASH_END = 13'h1fff;
    localparam logic [12:0] AP_START = 13'h0000;
    localparam logic [12:0] ISP_PAGE = 13'h0200;
    localparam logic [2:0] BOHI_2V4 = 3'h6;
    localparam logic [2:0] BOHI_3V6 = 3'h5;
    localparam logic [2:0] BOHI_4V2 = 3'h4;
    localparam logic [2:0] BOHI_2V7 = 3'h3;
    localparam logic [3:0] LVL_NONE = 4'h0;
    localparam logic [3:0] LVL_2V4 = 4'h1;
    localparam logic [3:0] LVL_3V6 = 4'h2;
    localparam logic [3:0] LVL_4V2 = 4'h4;
    localparam logic [3:0] LVL_2V7 = 4'h8;
    localparam int NBP = 4;
    localparam logic [2:0] CMD_RESET = 3'h0;
    localparam logic [2:0] CMD_RUN = 3'h1;
    localparam logic [2:0] CMD_STOP = 3'h2;
    localparam logic [2:0] CMD_STEP = 3'h3;
    localparam logic [2:0] CMD_CURSOR = 3'h4;
    localparam logic [2:0] CMD_SETBP = 3'h5;
    localparam logic [2:0] CMD_CLRBP = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        HOFL_RUN = 3'b001,
        HOFL_HALT = 3'b010,
        HOFL_STEP = 3'b100
    } hofl_dbg_t;
endpackage

// ===== dv/hofl_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module hofl_prog_model (
    input wire logic aclk,
    input wire logic prog_opt_wr_ready,
    output logic cpu_halted = 1'b0,
    output logic prog_opt_wr_valid = 1'b0,
    output logic [hofl_pkg::OPT_W-1:0] prog_opt_wr_data = '0,
    output logic prog_erase = 1'b0,
    output logic debug_clock_pin_i = 1'b0
);
    import hofl_pkg::*;
    // Link clock stands low outside a frame
    always @(posedge aclk)
        debug_clock_pin_i <= (prog_opt_wr_valid | prog_erase) & ~debug_clock_pin_i;
    // Halt first so the shared pins can be borrowed safely
    task automatic load_opt(input logic [OPT_W-1:0] w, input logic er,
                           input logic h, output logic ok);
        int i;
        @(posedge aclk);
        cpu_halted <= h;
        repeat ($urandom_range(3, 1)) @(posedge aclk);
        prog_opt_wr_data <= w;
        prog_opt_wr_valid <= ~er;
        prog_erase <= er;
        i = 0;
        do begin
            @(posedge aclk);
            i++;
        end while (!er && !prog_opt_wr_ready && i < 8);
        ok = er || prog_opt_wr_ready;
        prog_opt_wr_valid <= 1'b0;
        prog_erase <= 1'b0;
        prog_opt_wr_data <= ~w;
        @(posedge aclk);
        cpu_halted <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import hofl_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, cpu_fetch = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf, brownout_detector_high_level;
    logic [OPT_W-1:0] opt_nvm_word = 0, prog_opt_wr_data, o;
    logic prog_rd_valid = 0, reset_event = 0, reset_por = 0, dbg_cmd_valid = 0;
    logic brownout_detector_low = 0, brownout_detector_high = 0, ok;
    logic wdog_overflow_flag = 0, dbg_dat_out = 0, dbg_dat_oe = 0;
    logic [7:0] flash_rdata = 0, prog_rd_data, iap_lower_boundary, wd;
    logic [2:0] dbg_cmd = 0, wdog_prescale;
    logic [1:0] dbg_cmd_idx = 0, gpio_out = 0, gpio_oe = 0, gpio_in, rs;
    logic [12:0] dbg_cmd_addr = 0, cpu_pc = 0, boot_addr, isp_start_addr;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, prog_opt_wr_ready, cpu_halted, prog_opt_wr_valid;
    logic prog_erase, sys_reset_req, isp_present, wdog_enable, cpu_step;
    logic wdog_run_in_idle, wdog_run_in_powerdown, cpu_halt_req;
    logic debug_clock_pin_i, debug_clock_pin_o, debug_clock_pin_oe;
    logic debug_data_pin_i, debug_data_pin_o, debug_data_pin_oe;
    logic dbg_clk_in, dbg_dat_in;
    int err_count = 0, n_compared = 0;

    hofl_top dut_u (.*);
    hofl_prog_model prog_u (.*);
    // Released pad must not echo its last value
    assign debug_data_pin_i = debug_data_pin_oe ? debug_data_pin_o
                                                : ~debug_data_pin_o;
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cpu_pc <= 13'($urandom_range(3));
        cpu_fetch <= 1'($urandom);
        dbg_cmd_idx <= 2'($urandom);
        dbg_cmd_addr <= 13'($urandom_range(3));
    end

    function automatic logic [12:0] isp_of(logic [OPT_W-1:0] w);
        return w[3:1] == 0 ? FLASH_END
                           : FLASH_END + 13'h1 - 13'(w[3:1]) * ISP_PAGE;
    endfunction
    function automatic logic [3:0] lvl_of(logic [2:0] s);
        case (s)
            BOHI_2V4: return LVL_2V4;
            BOHI_3V6: return LVL_3V6;
            BOHI_4V2: return LVL_4V2;
            BOHI_2V7: return LVL_2V7;
            default: return LVL_NONE;
        endcase
    endfunction
    function automatic logic [7:0] wd_of(logic [OPT_W-1:0] w);
        return {1'b0, w[OPT_WDRE], w[OPT_WDHW], w[OPT_WDNS],
                w[OPT_WDHW] ? {w[OPT_WDIDLE], w[20:18]} : 4'h0};
    endfunction

    task chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic axi(logic w, logic [4:0] a, logic [31:0] d);
        int i = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(posedge aclk);
            i++;
        end while (!(w ? s_axi_awready && s_axi_wready : s_axi_arready)
                   && i < 50);
        s_axi_awvalid <= 0;
        s_axi_wvalid <= 0;
        s_axi_arvalid <= 0;
        while (!(w ? s_axi_bvalid : s_axi_rvalid) && i < 50) begin
            @(posedge aclk);
            i++;
        end
        rd = s_axi_rdata;
        rs = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        if (i >= 50) begin
            err_count++;
            finish_test;
        end
    endtask
    task rst(logic [OPT_W-1:0] w);
        @(posedge aclk);
        aresetn <= 0;
        opt_nvm_word <= w;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
    endtask
    task pulse(logic por, logic [2:0] c, logic dc);
        @(posedge aclk);
        reset_event <= !dc;
        reset_por <= por;
        dbg_cmd <= c;
        dbg_cmd_valid <= dc;
        @(posedge aclk);
        reset_event <= 0;
        dbg_cmd_valid <= 0;
        repeat (2) @(posedge aclk);
        if (!dc)
            chk("boot_addr", ((por && o[OPT_PUB]) || o[OPT_ARB]) && o[3:1]
                != 0 ? isp_of(o) : AP_START, boot_addr);
    endtask

    initial begin
        void'($urandom(71));
        for (int k = 0; k < 6; k++) begin
            o = k == 1 ? '1 : k == 0 ? OPT_ERASED : OPT_W'($urandom);
            rst(o);
            pulse(1'b1, 3'h0, 1'b0);
            pulse(1'b0, 3'h0, 1'b0);
            chk("isp_start", isp_of(o), isp_start_addr);
            chk("brownout_detector_high_level", lvl_of(o[11:9]), brownout_detector_high_level);
            chk("wdog_en", o[OPT_WDHW], wdog_enable);
            axi(0, REG_OPT, 0);
            chk("opt_reg", o, rd);
            axi(1, REG_OPT, 0);
            chk("opt_wr_resp", RESP_SLVERR, rs);
            axi(0, REG_WDOG, 0);
            chk("wdog_ctrl", wd_of(o), rd);
            wdog_overflow_flag <= 1;
            @(posedge aclk);
            wdog_overflow_flag <= 0;
            repeat (2) @(posedge aclk);
            chk("wd_rst", o[OPT_WDRE], sys_reset_req);
            // Bit 7 set also clears the overflow flag
            wd = 8'($urandom) | 8'h80;
            axi(1, REG_WDOG, {24'h0, wd});
            axi(0, REG_WDOG, 0);
            chk("wdog_prot", o[OPT_WP] ? wd_of(o) & WD_PROT_MASK | wd & 8'h20
                : wd & 8'h7f, rd);
            flash_rdata <= 8'($urandom);
            prog_rd_valid <= 1;
            @(posedge aclk);
            prog_rd_valid <= 0;
            @(posedge aclk);
            chk("dump", o[OPT_LOCK] ? 8'hff : flash_rdata, prog_rd_data);
            brownout_detector_low <= 1;
            repeat (2) @(posedge aclk);
            chk("bo_low", o[OPT_BO0RE], sys_reset_req);
            brownout_detector_low <= 0;
            brownout_detector_high <= 1;
            repeat (2) @(posedge aclk);
            chk("bo_high", o[OPT_BO1RE], sys_reset_req);
            brownout_detector_high <= 0;
        end
        rst(OPT_ERASED);
        gpio_oe <= 2'h2;
        axi(0, REG_DBG, 0);
        chk("dbg_en", 32'h1, rd);
        for (int v = 0; v < 2; v++) begin
            axi(1, REG_DBG, v);
            axi(0, REG_DBG, 0);
            chk("dbg_ctrl", v, rd);
            chk("pad_oe", !v, debug_data_pin_oe);
        end
        o = OPT_W'($urandom) | 22'h2;
        prog_u.load_opt(o, 1'b0, 1'b1, ok);
        axi(0, REG_OPT, 0);
        chk("prog_opt", {1'b1, o}, {ok, rd[OPT_W-1:0]});
        chk("prog_isp", isp_of(o), isp_start_addr);
        prog_u.load_opt(~o, 1'b0, 1'b0, ok);
        axi(0, REG_OPT, 0);
        chk("refused", {1'b0, o}, {ok, rd[OPT_W-1:0]});
        prog_u.load_opt(o, 1'b1, 1'b1, ok);
        repeat (3) @(posedge aclk);
        chk("erased", 0, {isp_present, brownout_detector_high_level, iap_lower_boundary});
        wd = 8'($urandom);
        axi(1, REG_IAP, wd);
        axi(0, REG_IAP, 0);
        chk("iap_reg", wd, rd);
        axi(0, 5'h14, 0);
        chk("unmapped", RESP_SLVERR, rs);
        pulse(1'b0, CMD_STOP, 1'b1);
        chk("halt", 1'b1, cpu_halt_req);
        pulse(1'b0, CMD_RUN, 1'b1);
        chk("run", 1'b0, cpu_halt_req);
        pulse(1'b0, CMD_SETBP, 1'b1);
        for (int t = 0; t < 200 && !cpu_halt_req; t++)
            @(posedge aclk);
        chk("bp_halt", 1'b1, cpu_halt_req);
        pulse(1'b0, CMD_STEP, 1'b1);
        chk("step", 1'b1, cpu_halt_req);
        finish_test;
    end
endmodule
`default_nettype wire

// ===== hw/hofl_top.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module hofl_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [hofl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hofl_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [hofl_pkg::OPT_W-1:0] opt_nvm_word,
    input wire logic prog_opt_wr_valid,
    output logic prog_opt_wr_ready,
    input wire logic [hofl_pkg::OPT_W-1:0] prog_opt_wr_data,
    input wire logic prog_erase,
    input wire logic prog_rd_valid,
    input wire logic [7:0] flash_rdata,
    output logic [7:0] prog_rd_data,
    input wire logic cpu_halted,
    input wire logic reset_event,
    input wire logic reset_por,
    input wire logic brownout_detector_low,
    input wire logic brownout_detector_high,
    input wire logic wdog_overflow_flag,
    output logic sys_reset_req,
    output logic [12:0] boot_addr,
    output logic [12:0] isp_start_addr,
    output logic isp_present,
    output logic [7:0] iap_lower_boundary,
    output logic [3:0] brownout_detector_high_level,
    output logic wdog_enable,
    output logic wdog_run_in_idle,
    output logic wdog_run_in_powerdown,
    output logic [2:0] wdog_prescale,
    input wire logic dbg_cmd_valid,
    input wire logic [2:0] dbg_cmd,
    input wire logic [1:0] dbg_cmd_idx,
    input wire logic [12:0] dbg_cmd_addr,
    input wire logic [12:0] cpu_pc,
    input wire logic cpu_fetch,
    output logic cpu_halt_req,
    output logic cpu_step,
    input wire logic debug_clock_pin_i,
    output logic debug_clock_pin_o,
    output logic debug_clock_pin_oe,
    input wire logic debug_data_pin_i,
    output logic debug_data_pin_o,
    output logic debug_data_pin_oe,
    output logic dbg_clk_in,
    output logic dbg_dat_in,
    input wire logic dbg_dat_out,
    input wire logic dbg_dat_oe,
    output logic [1:0] gpio_in,
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_oe
);
    import hofl_pkg::*;

    logic [OPT_W-1:0] opt_reg;
    logic loaded_reg;
    logic [7:0] wdog_control_reg;
    logic [7:0] debug_control_reg;
    logic [7:0] iap_reg;
    logic iap_load_reg;
    logic debug_pin_enable;
    logic prog_ok;
    logic [2:0] isp_code;
    logic [12:0] isp_start;
    logic bod_rst;
    logic wd_rst;
    logic wr_go;
    logic rd_go;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Option latch: checked bit is stored as 1
    assign prog_ok = cpu_halted;
    assign prog_opt_wr_ready = prog_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opt_reg <= OPT_ERASED;
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            opt_reg <= opt_nvm_word;
            loaded_reg <= 1'b1;
        end else if (prog_erase && prog_ok) begin
            opt_reg <= OPT_ERASED;
        end else if (prog_opt_wr_valid && prog_ok) begin
            opt_reg <= prog_opt_wr_data;
        end
    end

    // Code dump path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prog_rd_data <= 8'hff;
        end else if (prog_rd_valid) begin
            prog_rd_data <= opt_reg[OPT_LOCK] ? 8'hff : flash_rdata;
        end
    end

    // ISP area: start only, end fixed at flash end
    assign isp_code = opt_reg[OPT_ISP +: 3];
    assign isp_start = FLASH_END + 13'h0001 - ISP_PAGE * isp_code;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            isp_present <= 1'b0;
            isp_start_addr <= FLASH_END;
        end else begin
            isp_present <= (isp_code != 3'h0);
            isp_start_addr <= (isp_code != 3'h0) ? isp_start : FLASH_END;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brownout_detector_high_level <= LVL_NONE;
        end else begin
            unique case (opt_reg[OPT_BOHI +: 3])
                BOHI_2V4: brownout_detector_high_level <= LVL_2V4;
                BOHI_3V6: brownout_detector_high_level <= LVL_3V6;
                BOHI_4V2: brownout_detector_high_level <= LVL_4V2;
                BOHI_2V7: brownout_detector_high_level <= LVL_2V7;
                default: brownout_detector_high_level <= LVL_NONE;
            endcase
        end
    end

    // Reset sources and boot location
    assign bod_rst = (brownout_detector_low && opt_reg[OPT_BO0RE])
        || (brownout_detector_high && opt_reg[OPT_BO1RE]);
    assign wd_rst = wdog_control_reg[WD_OVF] && wdog_control_reg[WD_RSTEN];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= loaded_reg && (bod_rst || wd_rst);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_addr <= AP_START;
        end else if (loaded_reg && bod_rst) begin
            boot_addr <= AP_START;
        end else if (reset_event) begin
            if (isp_present && (opt_reg[OPT_ARB]
                || (reset_por && opt_reg[OPT_PUB]))) begin
                boot_addr <= isp_start_addr;
            end else begin
                boot_addr <= AP_START;
            end
        end
    end

    // Watchdog control: power-on load, then guarded software access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdog_control_reg <= WD_RST;
        end else if (!loaded_reg) begin
            wdog_control_reg[WD_RSTEN] <= opt_nvm_word[OPT_WDRE];
            wdog_control_reg[WD_PDRUN] <= opt_nvm_word[OPT_WDNS];
            if (opt_nvm_word[OPT_WDHW]) begin
                wdog_control_reg[WD_EN] <= 1'b1;
                wdog_control_reg[WD_IDL] <= opt_nvm_word[OPT_WDIDLE];
                wdog_control_reg[WD_PS +: 3] <= opt_nvm_word[OPT_PS +: 3];
            end
        end else begin
            if (wr_go && wr_addr == REG_WDOG && s_axi_wstrb[0]) begin
                wdog_control_reg[WD_EN] <= s_axi_wdata[WD_EN];
                if (!opt_reg[OPT_WP]) begin
                    wdog_control_reg[WD_RSTEN] <= s_axi_wdata[WD_RSTEN];
                    wdog_control_reg[WD_PDRUN] <= s_axi_wdata[WD_PDRUN];
                    wdog_control_reg[WD_IDL] <= s_axi_wdata[WD_IDL];
                    wdog_control_reg[WD_PS +: 3] <= s_axi_wdata[WD_PS +: 3];
                end
            end
            // Set beats write-one-to-clear so no overflow is missed
            if (wdog_overflow_flag) begin
                wdog_control_reg[WD_OVF] <= 1'b1;
            end else if (wr_go && wr_addr == REG_WDOG && s_axi_wstrb[0]
                && s_axi_wdata[WD_OVF]) begin
                wdog_control_reg[WD_OVF] <= 1'b0;
            end
        end
    end
    assign wdog_enable = wdog_control_reg[WD_EN];
    assign wdog_run_in_idle = wdog_control_reg[WD_IDL];
    assign wdog_run_in_powerdown = wdog_control_reg[WD_PDRUN];
    assign wdog_prescale = wdog_control_reg[WD_PS +: 3];

    // IAP boundary (upper address byte); zero size sits at ISP start.
    // Load waits one cycle for the latch; a zero boundary stays writable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iap_reg <= 8'h00;
            iap_load_reg <= 1'b0;
        end else if (!loaded_reg || (prog_ok && (prog_erase
            || prog_opt_wr_valid))) begin
            iap_load_reg <= 1'b1;
        end else if (iap_load_reg) begin
            iap_reg <= isp_start[12:5]
                - {1'b0, opt_reg[OPT_IAP +: 3], 4'h0};
            iap_load_reg <= 1'b0;
        end else if (wr_go && wr_addr == REG_IAP && s_axi_wstrb[0]) begin
            iap_reg <= s_axi_wdata[7:0];
        end
    end
    assign iap_lower_boundary = iap_reg;

    // Debug control: pins default to debug function
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debug_control_reg <= DBG_RST;
        end else if (prog_erase && prog_ok) begin
            debug_control_reg <= DBG_RST;
        end else if (wr_go && wr_addr == REG_DBG && s_axi_wstrb[0]) begin
            debug_control_reg <= s_axi_wdata[7:0];
        end
    end
    assign debug_pin_enable = debug_control_reg[DBG_EN];

    // Pad mux, registered so pads never glitch on a bit change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            debug_clock_pin_o <= 1'b0;
            debug_clock_pin_oe <= 1'b0;
            debug_data_pin_o <= 1'b0;
            debug_data_pin_oe <= 1'b0;
            dbg_clk_in <= 1'b0;
            dbg_dat_in <= 1'b0;
            gpio_in <= 2'h0;
        end else if (debug_pin_enable) begin
            debug_clock_pin_o <= 1'b0;
            debug_clock_pin_oe <= 1'b0;
            debug_data_pin_o <= dbg_dat_out;
            debug_data_pin_oe <= dbg_dat_oe;
            dbg_clk_in <= debug_clock_pin_i;
            dbg_dat_in <= debug_data_pin_i;
            gpio_in <= 2'h0;
        end else begin
            debug_clock_pin_o <= gpio_out[0];
            debug_clock_pin_oe <= gpio_oe[0];
            debug_data_pin_o <= gpio_out[1];
            debug_data_pin_oe <= gpio_oe[1];
            dbg_clk_in <= 1'b0;
            dbg_dat_in <= 1'b0;
            gpio_in <= {debug_data_pin_i, debug_clock_pin_i};
        end
    end

    // Debug run control with breakpoints
    hofl_dbg_t dbg_reg;
    logic [12:0] bp_addr_reg [NBP];
    logic [NBP-1:0] bp_arm_reg;
    logic [12:0] cursor_reg;
    logic cursor_arm_reg;
    logic [NBP-1:0] bp_hit;
    logic hit;

    genvar gi;
    generate
        for (gi = 0; gi < NBP; gi++) begin : g_bp
            assign bp_hit[gi] = bp_arm_reg[gi] && bp_addr_reg[gi] == cpu_pc;
        end
    endgenerate
    assign hit = cpu_fetch && (|bp_hit
        || (cursor_arm_reg && cursor_reg == cpu_pc));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bp_arm_reg <= '0;
            for (int i = 0; i < NBP; i++) begin
                bp_addr_reg[i] <= 13'h0000;
            end
        end else if (dbg_cmd_valid && dbg_cmd == CMD_SETBP) begin
            bp_addr_reg[dbg_cmd_idx] <= dbg_cmd_addr;
            bp_arm_reg[dbg_cmd_idx] <= 1'b1;
        end else if (dbg_cmd_valid && dbg_cmd == CMD_CLRBP) begin
            bp_arm_reg[dbg_cmd_idx] <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dbg_reg <= HOFL_RUN;
            cursor_reg <= 13'h0000;
            cursor_arm_reg <= 1'b0;
            cpu_step <= 1'b0;
        end else begin
            cpu_step <= 1'b0;
            unique case (dbg_reg)
                HOFL_RUN: begin
                    if (hit || (dbg_cmd_valid && (dbg_cmd == CMD_STOP
                        || dbg_cmd == CMD_RESET))) begin
                        dbg_reg <= HOFL_HALT;
                        cursor_arm_reg <= 1'b0;
                    end
                end
                HOFL_HALT: begin
                    if (dbg_cmd_valid && dbg_cmd == CMD_RUN) begin
                        dbg_reg <= HOFL_RUN;
                    end else if (dbg_cmd_valid && dbg_cmd == CMD_CURSOR) begin
                        dbg_reg <= HOFL_RUN;
                        cursor_reg <= dbg_cmd_addr;
                        cursor_arm_reg <= 1'b1;
                    end else if (dbg_cmd_valid && dbg_cmd == CMD_STEP) begin
                        dbg_reg <= HOFL_STEP;
                        cpu_step <= 1'b1;
                    end
                end
                HOFL_STEP: begin
                    if (cpu_fetch) begin
                        dbg_reg <= HOFL_HALT;
                    end
                end
            endcase
        end
    end
    assign cpu_halt_req = (dbg_reg != HOFL_RUN);

    // AXI4-Lite slave: write taken when address and data both present
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    assign s_axi_wready = s_axi_awready;
    assign wr_go = s_axi_awready;
    assign wr_addr = s_axi_awaddr;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            // Option and status words refuse software writes
            bresp_reg <= (wr_addr == REG_WDOG || wr_addr == REG_DBG
                || wr_addr == REG_IAP) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        unique case (s_axi_araddr)
            REG_OPT: rd_mux[OPT_W-1:0] = opt_reg;
            REG_WDOG: rd_mux[7:0] = wdog_control_reg;
            REG_DBG: rd_mux[7:0] = debug_control_reg;
            REG_IAP: rd_mux[7:0] = iap_reg;
            REG_BOOT: rd_mux = {7'h00, boot_addr, brownout_detector_high_level, isp_present,
                dbg_reg == HOFL_HALT, 6'h00};
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !rvalid_reg;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    AST_LOCK_DUMP: assert property (@(posedge aclk) disable iff (!aresetn)
        prog_rd_valid && opt_reg[OPT_LOCK] |=> prog_rd_data == 8'hff)
        else $error("locked dump leaked data");
    AST_DBG_DEFAULT: assert property (@(posedge aclk)
        !aresetn |=> debug_control_reg[DBG_EN])
        else $error("debug pins not default after reset");
    AST_SW_NO_OPT: assert property (@(posedge aclk) disable iff (!aresetn)
        loaded_reg && !(prog_ok && (prog_erase || prog_opt_wr_valid))
        |=> $stable(opt_reg))
        else $error("options changed without programming");
    AST_ERASE: assert property (@(posedge aclk) disable iff (!aresetn)
        loaded_reg && prog_erase && prog_ok
        |=> opt_reg == OPT_ERASED ##1 !isp_present)
        else $error("erase left options set");
    AST_BOD_AP: assert property (@(posedge aclk) disable iff (!aresetn)
        loaded_reg && bod_rst |=> sys_reset_req && boot_addr == AP_START)
        else $error("brown-out reset not to application start");
    AST_WDOG_WP: assert property (@(posedge aclk) disable iff (!aresetn)
        loaded_reg && opt_reg[OPT_WP]
        |=> $stable(wdog_control_reg & WD_PROT_MASK))
        else $error("protected watchdog field changed");
    AST_WDOG_RST: assert property (@(posedge aclk) disable iff (!aresetn)
        loaded_reg && wdog_control_reg[WD_OVF] && wdog_control_reg[WD_RSTEN]
        |=> sys_reset_req)
        else $error("watchdog overflow gave no reset");
    AST_BP_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
        dbg_reg == HOFL_RUN && cpu_fetch && |bp_hit |=> cpu_halt_req)
        else $error("breakpoint hit without halt");
    AST_ISP_START: assert property (@(posedge aclk) disable iff (!aresetn)
        isp_code == 3'h7 ##1 isp_code == 3'h7 |-> isp_start_addr == 13'h1200)
        else $error("largest ISP area start wrong");
endmodule
`default_nettype wire
